// file: hdl/rma_params.svh
// constants for the relocatable rom array interface
`ifndef RMA_PARAMS_SVH
`define RMA_PARAMS_SVH

// --------------------------------------------------------------------------
// geometry
// --------------------------------------------------------------------------
`define RMA_ADDR_W        24
`define RMA_ARRAY_AW      13
`define RMA_WORD_AW       12
`define RMA_ARRAY_WORDS   4096
`define RMA_REG_AW        5
`define RMA_REG_BLOCK     24'h7F_F820

// --------------------------------------------------------------------------
// register offsets inside the 32-byte block
// --------------------------------------------------------------------------
`define RMA_OFS_CONFIG    5'h00
`define RMA_OFS_SIGHI     5'h02
`define RMA_OFS_SIGLO     5'h06
`define RMA_OFS_BASEH     5'h04
`define RMA_OFS_BASEL     5'h08
`define RMA_OFS_BOOT0     5'h10
`define RMA_OFS_BOOT3     5'h16

// --------------------------------------------------------------------------
// config fields and reset values
// --------------------------------------------------------------------------
`define RMA_CFG_STOP      15
`define RMA_CFG_BOOT      14
`define RMA_CFG_LOCK      12
`define RMA_CFG_ASPC_HI   10
`define RMA_CFG_ASPC_LO   9
`define RMA_CFG_WAIT_HI   7
`define RMA_CFG_WAIT_LO   6
`define RMA_CFG_RESET     16'h0000
`define RMA_CFG_WMASK     16'hD6C0
`define RMA_BASE_RESET    24'hFF_0000
`define RMA_SIG_HI        8'h00
`define RMA_SIG_LO        16'h0000

// --------------------------------------------------------------------------
// timing: zero wait states gives a two-cycle byte or word access, three cycles for a long word
// --------------------------------------------------------------------------
`define RMA_MIN_CYCLES    2

`endif

// file: hdl/rma_pkg.sv
// types for the relocatable rom array interface
package rma_pkg;
    typedef enum logic [1:0] {
        RMA_IDLE,
        RMA_WAIT,
        RMA_DONE
    } rma_state_t;

    typedef enum logic [1:0] {
        RMA_SZ_BYTE,
        RMA_SZ_WORD,
        RMA_SZ_LONG
    } rma_size_t;
endpackage

// file: hdl/rma_rom_mem.sv
// mask-programmed word array with registered read data
`timescale 1ns/100ps
`include "rma_params.svh"
module rma_rom_mem #(
    parameter logic [15:0] FILL = 16'h0000
) (
    input  wire logic                     mclk,
    input  wire logic                     clkEn,
    input  wire logic [`RMA_WORD_AW-1:0]  rdAddr,
    output logic      [15:0]              rdData
);
    logic [15:0] romData_reg;

    // --------------------------------------------------------------------
    // contents: address pattern xor fill stands in for the mask image
    // --------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (clkEn) begin
            romData_reg <= {4'h0, rdAddr} ^ FILL;
        end
    end

    assign rdData = romData_reg;
endmodule // rma_rom_mem

// file: hdl/rma_rom_module.sv
// rom array interface: relocatable 8-Kbyte read-only array and control block
//
// Behaviour
// - 8-Kbyte read-only array placed on any 8-Kbyte aligned boundary
// - programmable wait states lengthen array accesses
// - zero wait states completes a byte or word access in two cycles, a long word in three; more waits, longer access
// - answer program fetches only, or program and data accesses
// - byte, word and long-word reads return correct array contents
// - optionally supply bootstrap words while reset is processed
// - config, base high/low, two signature registers, four bootstrap words
// - 32-byte block; unimplemented reads give zero, writes ignored
// - base loads mask default at reset; writable only while lock clear
// - decode assumes address bits 23..20 equal address bit 19
`timescale 1ns/100ps
`include "rma_params.svh"
module rma_rom_module #(
    parameter logic [`RMA_ADDR_W-1:0] BASE_DEFAULT = `RMA_BASE_RESET,
    parameter logic                   LOCK_MASKED  = 1'b0,
    parameter logic                   BOOT_DEFAULT = 1'b0,
    parameter logic [7:0]             SIG_HI       = `RMA_SIG_HI,   // arbitrary
    parameter logic [15:0]            SIG_LO       = `RMA_SIG_LO    // arbitrary
) (
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic                     clkEn,
    input  wire logic                     busReq,
    input  wire logic [`RMA_ADDR_W-1:0]   busAddr,
    input  wire logic                     busWrite,
    input  wire logic                     busProgram,
    input  wire rma_pkg::rma_size_t       busSize,
    input  wire logic [15:0]              busWdata,
    input  wire logic                     resetFetch,
    input  wire logic [1:0]               resetIndex,
    output logic                          busAck,
    output logic                          busClaim,
    output logic      [31:0]              busRdata,
    output logic      [15:0]              bootWord,
    output logic                          bootValid,
    output logic      [`RMA_ADDR_W-1:0]   arrayBase,
    output logic      [15:0]              configOut
);
    // --------------------------------------------------------------------
    // state
    // --------------------------------------------------------------------
    typedef struct packed {
        rma_pkg::rma_state_t          st;
        logic [15:0]                  cfg;
        logic [`RMA_ADDR_W-1:0]       base;
        logic [1:0]                   waitCnt;
        logic                         isArray;
        logic                         second;
        logic [`RMA_ARRAY_AW-1:0]     offs;
        rma_pkg::rma_size_t           size;
        logic [15:0]                  hiWord;
        logic                         ack;
        logic                         claim;
        logic [31:0]                  rdata;
        logic [15:0]                  boot;
        logic                         bootV;
    } rma_regs_t;

    rma_regs_t r_reg;
    rma_regs_t r_next;

    logic [15:0]              memData;
    logic [`RMA_WORD_AW-1:0]  memAddr;
    logic [`RMA_ADDR_W-1:0]   effAddr;
    logic                     hitArray;
    logic                     hitRegs;
    logic                     typeOk;
    logic [15:0]              regRd;
    logic [4:0]               regOfs;
    logic [15:0]              bootTab [0:3];

    // register block address; only bits 19..5 are decoded
    localparam logic [`RMA_ADDR_W-1:0] REG_BLOCK = `RMA_REG_BLOCK;

    // --------------------------------------------------------------------
    // bootstrap word contents held in the mask
    // --------------------------------------------------------------------
    assign bootTab[0] = 16'h0000;
    assign bootTab[1] = 16'h0200;
    assign bootTab[2] = 16'h0000;
    assign bootTab[3] = 16'h0000;

    // --------------------------------------------------------------------
    // address decode
    // --------------------------------------------------------------------
    assign effAddr  = {{4{busAddr[19]}}, busAddr[19:0]};
    assign hitArray = effAddr[`RMA_ADDR_W-1:`RMA_ARRAY_AW]
                      == r_reg.base[`RMA_ADDR_W-1:`RMA_ARRAY_AW];
    assign hitRegs  = effAddr[19:`RMA_REG_AW]
                      == REG_BLOCK[19:`RMA_REG_AW];
    assign typeOk   = busProgram | r_reg.cfg[`RMA_CFG_ASPC_HI];
    assign regOfs   = effAddr[`RMA_REG_AW-1:0];
    // next offset feeds the array so its registered word is ready one edge later
    assign memAddr  = r_next.offs[`RMA_ARRAY_AW-1:1];

    // --------------------------------------------------------------------
    // register read mux; holes read zero
    // --------------------------------------------------------------------
    always_comb begin
        case ({regOfs[4:1], 1'b0})
            `RMA_OFS_CONFIG: regRd = r_reg.cfg;
            `RMA_OFS_SIGHI:  regRd = {8'h00, SIG_HI};
            `RMA_OFS_BASEH:  regRd = {8'h00, r_reg.base[23:16]};
            `RMA_OFS_SIGLO:  regRd = SIG_LO;
            `RMA_OFS_BASEL:  regRd = r_reg.base[15:0];
            5'h10:           regRd = bootTab[0];
            5'h12:           regRd = bootTab[1];
            5'h14:           regRd = bootTab[2];
            `RMA_OFS_BOOT3:  regRd = bootTab[3];
            default:         regRd = 16'h0000;
        endcase
    end

    // --------------------------------------------------------------------
    // next-state logic
    // --------------------------------------------------------------------
    always_comb begin
        r_next       = r_reg;
        r_next.ack   = 1'b0;
        r_next.claim = 1'b0;
        r_next.bootV = 1'b0;
        // bootstrap supply during reset processing
        if (resetFetch && r_reg.cfg[`RMA_CFG_BOOT]) begin
            r_next.boot  = bootTab[resetIndex];
            r_next.bootV = 1'b1;
        end
        case (r_reg.st)
            rma_pkg::RMA_IDLE: begin
                // no new access in the ack cycle: the master still holds its request
                if (busReq && hitRegs && !r_reg.ack) begin
                    r_next.claim = 1'b1;
                    r_next.ack   = 1'b1;
                    r_next.rdata = {16'h0000, busWrite ? 16'h0000 : regRd};
                    if (busWrite && regOfs[4:1] == 4'h0) begin
                        r_next.cfg = (busWdata & `RMA_CFG_WMASK)
                                     | (r_reg.cfg & ~`RMA_CFG_WMASK);
                        if (LOCK_MASKED) r_next.cfg[`RMA_CFG_LOCK] = 1'b1;
                    end
                    if (busWrite && !r_reg.cfg[`RMA_CFG_LOCK]) begin
                        if ({regOfs[4:1], 1'b0} == `RMA_OFS_BASEH) begin
                            r_next.base[23:16] = busWdata[7:0];
                        end
                        if ({regOfs[4:1], 1'b0} == `RMA_OFS_BASEL) begin
                            r_next.base[15:`RMA_ARRAY_AW] = busWdata[15:`RMA_ARRAY_AW];
                        end
                    end
                end else if (busReq && hitArray && typeOk && !r_reg.ack
                             && !r_reg.cfg[`RMA_CFG_STOP]) begin
                    r_next.claim   = 1'b1;
                    r_next.isArray = !busWrite;
                    r_next.offs    = effAddr[`RMA_ARRAY_AW-1:0];
                    r_next.size    = busSize;
                    r_next.second  = 1'b0;
                    r_next.waitCnt = r_reg.cfg[`RMA_CFG_WAIT_HI:`RMA_CFG_WAIT_LO];
                    r_next.st      = rma_pkg::RMA_WAIT;
                end
            end
            rma_pkg::RMA_WAIT: begin
                r_next.claim = 1'b1;
                if (r_reg.waitCnt != 2'd0) begin
                    r_next.waitCnt = r_reg.waitCnt - 2'd1;
                end else if (r_reg.size == rma_pkg::RMA_SZ_LONG && !r_reg.second) begin
                    r_next.hiWord  = memData;
                    r_next.second  = 1'b1;
                    r_next.offs    = r_reg.offs + `RMA_ARRAY_AW'(2);
                    r_next.waitCnt = r_reg.cfg[`RMA_CFG_WAIT_HI:`RMA_CFG_WAIT_LO];
                end else begin
                    r_next.st  = rma_pkg::RMA_IDLE;
                    r_next.ack = 1'b1;
                    if (!r_reg.isArray) begin
                        r_next.rdata = 32'h0000_0000;
                    end else begin
                        case (r_reg.size)
                            rma_pkg::RMA_SZ_BYTE:
                                r_next.rdata = {24'h00_0000, r_reg.offs[0]
                                                ? memData[7:0] : memData[15:8]};
                            rma_pkg::RMA_SZ_LONG:
                                r_next.rdata = {r_reg.hiWord, memData};
                            default:
                                r_next.rdata = {16'h0000, memData};
                        endcase
                    end
                end
            end
            default: r_next.st = rma_pkg::RMA_IDLE;
        endcase
    end

    // --------------------------------------------------------------------
    // state register; base and boot option take mask defaults
    // --------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            r_reg        <= '0;
            r_reg.st     <= rma_pkg::RMA_IDLE;
            r_reg.base   <= BASE_DEFAULT;
            r_reg.cfg    <= `RMA_CFG_RESET | (16'(BOOT_DEFAULT) << `RMA_CFG_BOOT)
                            | (16'(LOCK_MASKED) << `RMA_CFG_LOCK);
        end else if (clkEn) begin
            r_reg <= r_next;
        end
    end

    // --------------------------------------------------------------------
    // array storage
    // --------------------------------------------------------------------
    rma_rom_mem u_mem (
        .mclk   (mclk),
        .clkEn  (clkEn),
        .rdAddr (memAddr),
        .rdData (memData)
    );

    // outputs straight from flip-flops
    assign busAck    = r_reg.ack;
    assign busClaim  = r_reg.claim;
    assign busRdata  = r_reg.rdata;
    assign bootWord  = r_reg.boot;
    assign bootValid = r_reg.bootV;
    assign arrayBase = r_reg.base;
    assign configOut = r_reg.cfg;
endmodule // rma_rom_module

// file: testbench/rma_cpu_model.sv
// bus master model standing in for the processor on the module bus
`timescale 1ns/100ps
module rma_cpu_model (
    input  wire logic          mclk,
    input  wire logic          busAck,
    output logic               busReq,
    output logic [23:0]        busAddr,
    output logic               busWrite,
    output logic               busProgram,
    output rma_pkg::rma_size_t busSize,
    output logic [15:0]        busWdata
);
    // idle bus at time zero
    initial begin
        busReq = 1'b0;
        busAddr = 24'h0;
        busWrite = 1'b0;
        busProgram = 1'b0;
        busSize = rma_pkg::RMA_SZ_WORD;
        busWdata = 16'h0;
    end
    // one transfer held until ack or for at most 12 cycles; module map assumed set throughout
    task automatic xfer(input logic [23:0] a, input logic w, p, input rma_pkg::rma_size_t s,
                        input logic [15:0] d, output bit ok);
        @(posedge mclk);
        busReq <= 1'b1;
        busAddr <= a;
        busWrite <= w;
        busProgram <= p;
        busSize <= s;
        busWdata <= d;
        ok = 1'b0;
        for (int i = 0; i < 12 && !ok; i++) begin
            @(posedge mclk);
            ok = (busAck === 1'b1);
        end
        // released address and data lines show the inverse, not the old value
        busReq <= 1'b0;
        busAddr <= ~a;
        busWdata <= ~d;
    endtask
endmodule // rma_cpu_model

// file: testbench/rma_rom_module_properties.sv
// concurrent checks on the rom array interface ports
`timescale 1ns/100ps
module rma_rom_module_chk #(
    parameter logic [23:0] BASE_DEFAULT = 24'hFF_0000
) (
    input wire logic               mclk,
    input wire logic               nrst,
    input wire logic [23:0]        busAddr,
    input wire logic               busWrite,
    input wire logic               busProgram,
    input wire rma_pkg::rma_size_t busSize,
    input wire logic               resetFetch,
    input wire logic               busAck,
    input wire logic               busClaim,
    input wire logic [31:0]        busRdata,
    input wire logic               bootValid,
    input wire logic [23:0]        arrayBase,
    input wire logic [15:0]        configOut
);
    logic       arrHit;
    logic       regHit;
    logic [3:0] claimCnt_reg;
    // window decode, upper bits taken as copies of bit 19
    assign arrHit = busAddr[19:13] == arrayBase[19:13];
    assign regHit = busAddr[19:5] == 15'h7FC1;
    // cycles of claim before the ack
    always_ff @(posedge mclk) begin
        claimCnt_reg <= (!nrst || busAck || !busClaim) ? 4'h0 : claimCnt_reg + 4'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    claim_in_window_a: assert property ($rose(busClaim) |-> regHit || arrHit)
        else $error("claim outside any window");
    data_gate_a: assert property ($rose(busClaim) && arrHit && !busProgram |-> configOut[10])
        else $error("data access claimed while disabled");
    word_time_a: assert property (busAck && arrHit && !busWrite && busSize != rma_pkg::RMA_SZ_LONG
        |-> claimCnt_reg == 4'h1 + {2'h0, configOut[7:6]}) else $error("word access latency wrong");
    long_time_a: assert property (busAck && arrHit && !busWrite && busSize == rma_pkg::RMA_SZ_LONG
        |-> claimCnt_reg == 4'h2 + {1'h0, configOut[7:6], 1'h0}) else $error("long latency wrong");
    ack_single_a: assert property (busAck |=> !busAck)
        else $error("ack longer than one cycle");
    base_lock_a: assert property (configOut[12] |=> $stable(arrayBase))
        else $error("base moved while locked");
    base_reset_a: assert property (disable iff (1'b0) !nrst |=> arrayBase == BASE_DEFAULT)
        else $error("base not default after reset");
    rom_readonly_a: assert property (busAck && arrHit && busWrite |-> busRdata == 32'h0)
        else $error("array write returned data");
    boot_supply_a: assert property (resetFetch && configOut[14] |-> ##[1:3] bootValid)
        else $error("bootstrap word not supplied");
endmodule // rma_rom_module_chk

// file: testbench/testbench.sv
// self-checking bench for the relocatable rom array interface
`timescale 1ns/100ps
module testbench;
    localparam logic [23:0]        REGS = 24'h7F_F820;
    localparam logic [32:0]        DC   = 33'h1_0000_0000;
    localparam rma_pkg::rma_size_t SZB  = rma_pkg::RMA_SZ_BYTE;
    localparam rma_pkg::rma_size_t SZW  = rma_pkg::RMA_SZ_WORD;
    localparam rma_pkg::rma_size_t SZL  = rma_pkg::RMA_SZ_LONG;
    logic               mclk, nrst, clkEn, resetFetch, bootValid;
    logic               busReq, busWrite, busProgram, busAck, busClaim;
    logic [1:0]         resetIndex;
    logic [23:0]        busAddr, arrayBase, a;
    rma_pkg::rma_size_t busSize;
    logic [15:0]        busWdata, bootWord, configOut, v;
    logic [31:0]        busRdata;
    logic [32:0]        expQ[$];
    logic [32:0]        e;
    integer             seed = 32'hea41;
    int                 badCount = 0;
    int                 cmpCount = 0;
    int                 cyc = 0;
    rma_rom_module DUT (.mclk, .nrst, .clkEn, .busReq, .busAddr, .busWrite, .busProgram,
        .busSize, .busWdata, .resetFetch, .resetIndex, .busAck, .busClaim, .busRdata,
        .bootWord, .bootValid, .arrayBase, .configOut);
    rma_cpu_model cpu (.mclk, .busAck, .busReq, .busAddr, .busWrite, .busProgram, .busSize,
        .busWdata);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // expected array word: index of the word
    function automatic logic [15:0] wv(input logic [23:0] x);
        return {4'h0, x[12:1]};
    endfunction
    // expected bootstrap word for an index
    function automatic logic [15:0] bw(input logic [1:0] i);
        return (i == 2'h1) ? 16'h0200 : 16'h0000;
    endfunction
    task automatic check(input logic [31:0] got, exp, input string what);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one bus transfer; when an ack is wanted the expected data is queued for the monitor
    task automatic acc(input logic [23:0] x, input logic w, p, input rma_pkg::rma_size_t s,
                       input logic [15:0] d, input logic [32:0] ex, input bit want);
        bit ok;
        if (want) expQ.push_back(ex);
        cpu.xfer(x, w, p, s, d, ok);
        check({31'h0, ok}, {31'h0, want}, "ack");
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // monitor: read data against the oldest note, plus the hang limit
    always @(posedge mclk) begin
        cyc++;
        if (busAck === 1'b1) begin
            if (expQ.size() == 0) begin
                badCount++;
                $display("[ERR] %0t unexpected ack", $time);
            end else begin
                e = expQ.pop_front();
                if (!e[32]) check(busRdata, e[31:0], "rdata");
            end
        end
        if (cyc > 5000) begin
            badCount++;
            close_out();
        end
    end
    // main sequence
    initial begin
        nrst = 1'b0;
        clkEn = 1'b1;
        resetFetch = 1'b0;
        resetIndex = 2'h0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        check({8'h0, arrayBase}, 32'h00FF_0000, "base");
        check({16'h0, configOut}, 32'h0, "config");
        acc(REGS + 24'h2, 0, 0, SZW, 16'h0, 33'h0, 1);
        acc(REGS + 24'hA, 1, 0, SZW, 16'hFFFF, DC, 1);
        acc(REGS + 24'hA, 0, 0, SZW, 16'h0, 33'h0, 1);
        $display("test registers done");
        for (int w = 0; w < 4; w++) begin
            acc(REGS, 1, 0, SZW, {8'h0, 2'(w), 6'h0}, DC, 1);
            a = 24'hFF_0000 | (24'($random(seed)) & 24'h1FFC);
            v = wv(a);
            acc(a, 0, 1, SZW, 16'h0, {17'h0, v}, 1);
            acc(a, 0, 1, SZB, 16'h0, {25'h0, v[15:8]}, 1);
            acc(a + 24'h1, 0, 1, SZB, 16'h0, {25'h0, v[7:0]}, 1);
            acc(a, 0, 1, SZL, 16'h0, {1'b0, v, wv(a + 24'h2)}, 1);
        end
        $display("test waits and sizes done");
        acc(a, 0, 0, SZW, 16'h0, 33'h0, 0);
        acc(REGS, 1, 0, SZW, 16'h0400, DC, 1);
        acc(a, 0, 0, SZW, 16'h0, {17'h0, v}, 1);
        acc(a, 1, 0, SZW, 16'($random(seed)), 33'h0, 1);
        acc(a, 0, 0, SZW, 16'h0, {17'h0, v}, 1);
        $display("test data access done");
        // new base kept clear of the unreachable top range
        acc(REGS + 24'h4, 1, 0, SZW, 16'h00F8, DC, 1);
        @(posedge mclk);
        check({8'h0, arrayBase}, 32'h00F8_0000, "moved");
        acc(24'hF8_0000 | a[12:0], 0, 1, SZW, 16'h0, {17'h0, v}, 1);
        acc(a, 0, 1, SZW, 16'h0, 33'h0, 0);
        acc(REGS, 1, 0, SZW, 16'h1400, DC, 1);
        acc(REGS + 24'h4, 1, 0, SZW, 16'h00FC, DC, 1);
        @(posedge mclk);
        check({8'h0, arrayBase}, 32'h00F8_0000, "locked");
        acc(REGS, 1, 0, SZW, 16'h8400, DC, 1);
        acc(24'hF8_0000 | a[12:0], 0, 1, SZW, 16'h0, 33'h0, 0);
        $display("test relocation done");
        acc(REGS, 1, 0, SZW, 16'h4000, DC, 1);
        resetIndex <= 2'($random(seed));
        resetFetch <= 1'b1;
        @(posedge mclk);
        resetFetch <= 1'b0;
        @(negedge mclk);
        check({15'h0, bootValid, bootWord}, {15'h0, 1'b1, bw(resetIndex)}, "boot");
        repeat (4) @(posedge mclk);
        nrst <= 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        check({8'h0, arrayBase}, 32'h00FF_0000, "base again");
        $display("test boot and reset done");
        close_out();
    end
endmodule // testbench
bind rma_rom_module rma_rom_module_chk #(.BASE_DEFAULT(BASE_DEFAULT)) chk (.mclk, .nrst,
    .busAddr, .busWrite, .busProgram, .busSize, .resetFetch, .busAck, .busClaim, .busRdata,
    .bootValid, .arrayBase, .configOut);
